//--- logic/frc_host.sv
// Purpose: host controller issuing command writes and reads to the flash pins
// Assumes: single clock; flash pins are timed by whole-cycle strobes
// Notes:   registered state machine; commands enter on a valid/ready port
`timescale 1ns/1ps
module frc_host (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Command port
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready,
    input  wire logic [1:0]                 cmd_op,
    input  wire logic [frc_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [7:0]                 cmd_data,
    output logic                            rsp_valid,
    output logic [7:0]                      rsp_data,
    output logic                            init_done,
    // Flash pins
    output logic [frc_pkg::ADDR_W-1:0]      fl_addr,
    output logic [7:0]                      fl_dq_o,
    output logic                            fl_dq_oe_n,
    input  wire logic [7:0]                 fl_dq_i,
    output logic                            fl_ce_n,
    output logic                            fl_we_n,
    output logic                            fl_oe_n
);
    frc_pkg::frc_state_e state_q, state_d;
    logic [frc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] op_q, op_d;
    logic       step_q, step_d;
    logic       init_q, init_d;
    logic       busy_q, busy_d;
    logic [frc_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] data_q, data_d, rd_q, rd_d;
    logic       rsp_q, rsp_d;

    function automatic logic [frc_pkg::CNT_W-1:0] cyc(input int n);
        cyc = frc_pkg::CNT_W'(n - 1);
    endfunction

    assign cmd_ready  = (state_q == frc_pkg::ST_IDLE) && init_q && !busy_q;
    assign rsp_valid  = rsp_q;
    assign rsp_data   = rd_q;
    assign init_done  = init_q;
    assign fl_addr    = addr_q;
    assign fl_dq_o    = data_q;
    assign fl_ce_n    = (state_q == frc_pkg::ST_IDLE) || (state_q == frc_pkg::ST_DONE);
    assign fl_we_n    = (state_q != frc_pkg::ST_WLOW);
    assign fl_oe_n    = (state_q != frc_pkg::ST_RLOW);
    assign fl_dq_oe_n = !((state_q == frc_pkg::ST_WLOW) || (state_q == frc_pkg::ST_WHIGH));

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        op_d    = op_q;
        step_d  = step_q;
        init_d  = init_q;
        busy_d  = busy_q;
        addr_d  = addr_q;
        data_d  = data_q;
        rd_d    = rd_q;
        rsp_d   = 1'b0;
        unique case (state_q)
            frc_pkg::ST_IDLE: begin
                if (!init_q && !busy_q) begin
                    // Kill any erase/program left running across our reset
                    op_d    = frc_pkg::OP_RESET_SEQ;
                    busy_d  = 1'b1;
                    step_d  = 1'b0;
                    data_d  = frc_pkg::CMD_RESET;
                    state_d = frc_pkg::ST_WLOW;
                    cnt_d   = cyc(frc_pkg::WP_CYC);
                end else if (cmd_valid && cmd_ready) begin
                    op_d   = cmd_op;
                    busy_d = 1'b1;
                    step_d = 1'b0;
                    addr_d = cmd_addr;
                    cnt_d  = cyc(frc_pkg::WP_CYC);
                    unique case (cmd_op)
                        frc_pkg::OP_WRITE: begin
                            // Any command byte passes; read code masks a device
                            data_d  = cmd_data;
                            state_d = frc_pkg::ST_WLOW;
                        end
                        frc_pkg::OP_RESET_SEQ: begin
                            data_d  = frc_pkg::CMD_RESET;
                            state_d = frc_pkg::ST_WLOW;
                        end
                        frc_pkg::OP_ID_READ: begin
                            // Auto-select by command, no high voltage on address
                            data_d  = frc_pkg::CMD_ID_B;
                            state_d = frc_pkg::ST_WLOW;
                        end
                        default: begin
                            cnt_d   = cyc(frc_pkg::RC_CYC);
                            state_d = frc_pkg::ST_RLOW;
                        end
                    endcase
                end
            end
            frc_pkg::ST_WLOW: begin
                if (cnt_q == '0) begin
                    cnt_d   = cyc(frc_pkg::WPH_CYC);
                    state_d = frc_pkg::ST_WHIGH;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            frc_pkg::ST_WHIGH: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else if (op_q == frc_pkg::OP_RESET_SEQ && !step_q) begin
                    // Second consecutive reset write completes the abort
                    step_d  = 1'b1;
                    cnt_d   = cyc(frc_pkg::WP_CYC);
                    state_d = frc_pkg::ST_WLOW;
                end else if (op_q == frc_pkg::OP_RESET_SEQ) begin
                    // Leave the part in array read after the abort
                    op_d    = frc_pkg::OP_WRITE;
                    data_d  = frc_pkg::CMD_READ;
                    cnt_d   = cyc(frc_pkg::WP_CYC);
                    state_d = frc_pkg::ST_WLOW;
                end else if (op_q == frc_pkg::OP_ID_READ) begin
                    // Identifier stays active until our next command write
                    cnt_d   = cyc(frc_pkg::RC_CYC);
                    state_d = frc_pkg::ST_RLOW;
                end else begin
                    state_d = frc_pkg::ST_DONE;
                end
            end
            frc_pkg::ST_RLOW: begin
                if (cnt_q == '0) begin
                    rd_d    = fl_dq_i;
                    rsp_d   = 1'b1;
                    state_d = frc_pkg::ST_DONE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            frc_pkg::ST_DONE: begin
                init_d  = 1'b1;
                busy_d  = 1'b0;
                state_d = frc_pkg::ST_IDLE;
            end
            default: state_d = frc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= frc_pkg::ST_IDLE;
            cnt_q   <= '0;
            op_q    <= frc_pkg::OP_WRITE;
            step_q  <= 1'b0;
            init_q  <= 1'b0;
            busy_q  <= 1'b0;
            addr_q  <= '0;
            data_q  <= 8'h00;
            rd_q    <= 8'h00;
            rsp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            op_q    <= op_d;
            step_q  <= step_d;
            init_q  <= init_d;
            busy_q  <= busy_d;
            addr_q  <= addr_d;
            data_q  <= data_d;
            rd_q    <= rd_d;
            rsp_q   <= rsp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobes never overlap, so a write can never be mistaken for a read
    we_oe_excl_a: assert property (@(posedge clk) disable iff (reset)
        !(!fl_we_n && !fl_oe_n)) else $error("write and read strobes overlap");

    bus_drive_a: assert property (@(posedge clk) disable iff (reset)
        !fl_oe_n |-> fl_dq_oe_n) else $error("host drives data during read");

    // The part latches the byte on the rising strobe, so data must still stand there
    wr_hold_a: assert property (@(posedge clk) disable iff (reset)
        $rose(fl_we_n) |-> !fl_ce_n && !fl_dq_oe_n && $stable(fl_dq_o) && $stable(fl_addr))
        else $error("write data or enable moved at strobe end");

    we_width_a: assert property (@(posedge clk) disable iff (reset)
        $fell(fl_we_n) |-> !fl_we_n [*2]) else $error("write pulse too short");

    // Read strobe spans the slowest access time before the byte is taken
    rd_width_a: assert property (@(posedge clk) disable iff (reset)
        $fell(fl_oe_n) |-> !fl_oe_n [*5]) else $error("read strobe too short");

    // A byte taken off the strobe would be stale bus noise
    rsp_sample_a: assert property (@(posedge clk) disable iff (reset)
        rsp_valid |-> !$past(fl_oe_n) && !$past(fl_ce_n)) else $error("read byte taken off strobe");

    rsp_pulse_a: assert property (@(posedge clk) disable iff (reset)
        rsp_valid |=> !rsp_valid) else $error("read answer longer than one cycle");

    reset_pair_a: assert property (@(posedge clk) disable iff (reset)
        $rose(step_q) |-> (op_q == frc_pkg::OP_RESET_SEQ) && (data_q == frc_pkg::CMD_RESET))
        else $error("second reset write lost its code");

    // Before init only the abort pattern may reach the part
    init_first_a: assert property (@(posedge clk) disable iff (reset)
        !init_q && !fl_we_n |-> (data_q == frc_pkg::CMD_RESET) || (data_q == frc_pkg::CMD_READ))
        else $error("command written before reset sequence");

    // Either auto-select code is legal; this block only sends the second
    id_code_a: assert property (@(posedge clk) disable iff (reset)
        (op_q == frc_pkg::OP_ID_READ) && !fl_we_n |->
        (data_q == frc_pkg::CMD_ID_A) || (data_q == frc_pkg::CMD_ID_B))
        else $error("identifier write carries wrong code");

    id_addr_a: assert property (@(posedge clk) disable iff (reset)
        (op_q == frc_pkg::OP_ID_READ) && !fl_oe_n |-> $stable(fl_addr))
        else $error("identifier read address moved");
endmodule

//--- logic/frc_pkg.sv
// Purpose: constants for the flash command host controller
// Assumes: byte-wide flash with 18 address lines, 25 MHz host clock
// Notes:   write and read strobe timing rounded up to whole cycles
package frc_pkg;
    localparam int          ADDR_W        = 18;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  CMD_READ      = 8'h00;
    localparam logic [7:0]  CMD_PROG_SET  = 8'h40;
    localparam logic [7:0]  CMD_ID_A      = 8'h80;
    localparam logic [7:0]  CMD_ID_B      = 8'h90;
    localparam logic [7:0]  CMD_RESET     = 8'hff;
    localparam logic [17:0] ID_MFR_ADDR   = 18'h00000;
    localparam logic [17:0] ID_DEV_ADDR   = 18'h00001;
    localparam int          CLK_NS        = 40;
    localparam int          T_WP_NS       = 50;
    localparam int          T_WPH_NS      = 20;
    localparam int          T_RC_NS       = 200;
    localparam int          WP_CYC        = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WPH_CYC       = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RC_CYC        = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CNT_W         = 4;
    localparam logic [1:0]  OP_WRITE      = 2'h0;
    localparam logic [1:0]  OP_READ       = 2'h1;
    localparam logic [1:0]  OP_RESET_SEQ  = 2'h2;
    localparam logic [1:0]  OP_ID_READ    = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WLOW  = 3'b001,
        ST_WHIGH = 3'b011,
        ST_RLOW  = 3'b010,
        ST_DONE  = 3'b110
    } frc_state_e;
endpackage

//--- test/frc_flash_model.sv
// Purpose: behavioural byte-wide flash answering the host's pins
// Assumes: 16 array bytes, address bits above 3 ignored for the array
// Notes:   program write returns to read mode; verify step not modelled
`timescale 1ns/1ps
module frc_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'hc3  // Arbitrary value
) (
    // Host pins
    input  wire logic [17:0] addr,
    input  wire logic [7:0]  dq_in,
    input  wire logic        dq_oe_n,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    output logic [7:0]       dq_out,
    // Supply
    input  wire logic        vpp_hi,
    input  wire logic        logic_supply,
    input  wire logic        identifier_high_voltage
);
    logic [7:0] mem [16];
    logic [1:0] mode_q;
    logic       ff_q;
    logic [7:0] last_q;
    logic [7:0] rd_val;
    logic       wr_ok;
    logic       id_view;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'h5a ^ i[7:0];
        mode_q = 2'h0;
        ff_q   = 1'b0;
        last_q = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Commands take effect at the end of the write strobe
    // A byte the host does not drive, or with no logic supply, changes nothing
    assign wr_ok = (ce_n === 1'b0) && (dq_oe_n === 1'b0) && (logic_supply === 1'b1);
    always @(posedge we_n) if (wr_ok) begin
        if (mode_q == 2'h2 && dq_in == 8'hff) begin
            if (ff_q) mode_q = 2'h0;
            ff_q = ~ff_q;
        end else if (mode_q == 2'h2) begin
            if (vpp_hi) mem[addr[3:0]] = dq_in;
            mode_q = 2'h0;
            ff_q   = 1'b0;
        end else begin
            case (dq_in)
                8'h00, 8'hff: mode_q = 2'h0;
                8'h40: mode_q = 2'h2;
                8'h80, 8'h90: mode_q = 2'h1;
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Logic supply rising with high programming supply lands in read mode
    always @(posedge logic_supply) if (vpp_hi) begin
        mode_q = 2'h0;
        ff_q   = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Released bus shows the inverse so a late sample cannot pass by luck
    assign id_view = (mode_q == 2'h1) || (identifier_high_voltage === 1'b1);
    assign rd_val = !id_view ? mem[addr[3:0]] :
                    (addr == 18'h0) ? MFR_CODE :
                    (addr == 18'h1) ? DEV_CODE : 8'h00;
    always @(posedge oe_n) last_q <= rd_val;
    assign dq_out = (ce_n === 1'b0 && oe_n === 1'b0) ? rd_val : ~last_q;
endmodule

//--- test/frc_host_tb.sv
// Purpose: scenario bench for the flash command host
// Assumes: flash model array bytes start as 5a xor address
// Notes:   each scenario task judges its own reads
`timescale 1ns/1ps
module frc_host_tb;
    localparam logic [7:0] MFR = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEV = 8'hc3; // Arbitrary value
    logic        clk = 0, reset = 1, cmd_valid = 0, vpp_hi = 1, logic_supply = 1;
    logic        identifier_high_voltage = 0;
    logic [1:0]  cmd_op = 0;
    logic [17:0] cmd_addr = 0, fl_addr;
    logic [7:0]  cmd_data = 0, rsp_data, fl_dq_o, fl_dq_i;
    logic        cmd_ready, rsp_valid, init_done, fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n;
    int          errors = 0, checks_done = 0;
    frc_host dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .init_done(init_done), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
        .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n));
    frc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.addr(fl_addr),
        .dq_in(fl_dq_o), .dq_oe_n(fl_dq_oe_n), .ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n),
        .dq_out(fl_dq_i), .vpp_hi(vpp_hi), .logic_supply(logic_supply),
        .identifier_high_voltage(identifier_high_voltage));
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Request held until ready is seen before the taking edge
    task automatic issue(input logic [1:0] op, input logic [17:0] a, input logic [7:0] d);
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        do @(negedge clk); while (cmd_ready !== 1'b1);
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [1:0] op, input logic [17:0] a, input logic [7:0] exp);
        int n;
        issue(op, a, 8'h00);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        if (rsp_valid !== 1'b1) errors++;
        check("rsp_data", rsp_data, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_powerup;
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        if (init_done !== 1'b1) errors++;
        rd(2'h1, 18'h3, 8'h5a ^ 8'h03);
    endtask
    task automatic t_ident;
        rd(2'h3, 18'h0, MFR);
        rd(2'h3, 18'h1, DEV);
        rd(2'h1, 18'h0, MFR);
        issue(2'h0, 18'h0, 8'h00);
        rd(2'h1, 18'h0, 8'h5a);
        issue(2'h0, 18'h0, 8'h80);
        rd(2'h1, 18'h1, DEV);
        issue(2'h2, 18'h0, 8'h00);
        rd(2'h1, 18'h1, 8'h5a ^ 8'h01);
    endtask
    task automatic t_abort;
        issue(2'h0, 18'h0, 8'h40);
        issue(2'h2, 18'h0, 8'h00);
        rd(2'h1, 18'h0, 8'h5a);
        issue(2'h0, 18'h0, 8'h40);
        issue(2'h0, 18'h6, 8'h33);
        rd(2'h1, 18'h6, 8'h33);
        issue(2'h0, 18'h7, 8'h12);
        rd(2'h1, 18'h7, 8'h5a ^ 8'h07);
    endtask
    task automatic t_lowvpp;
        vpp_hi = 1'b0;
        issue(2'h0, 18'h0, 8'h40);
        issue(2'h0, 18'h8, 8'h77);
        rd(2'h1, 18'h8, 8'h5a ^ 8'h08);
        vpp_hi = 1'b1;
    endtask
    task automatic t_supply;
        issue(2'h0, 18'h0, 8'h40);
        repeat (4) @(posedge clk);
        #1 logic_supply = 1'b0;
        issue(2'h0, 18'ha, 8'h55);
        repeat (4) @(posedge clk);
        #1 logic_supply = 1'b1;
        issue(2'h0, 18'hb, 8'h66);
        rd(2'h1, 18'ha, 8'h5a ^ 8'h0a);
        rd(2'h1, 18'hb, 8'h5a ^ 8'h0b);
    endtask
    task automatic t_idpin;
        identifier_high_voltage = 1'b1;
        rd(2'h1, 18'h1, DEV);
        identifier_high_voltage = 1'b0;
        rd(2'h1, 18'h1, 8'h5a ^ 8'h01);
    endtask
    // Host reset with a set-up pending: the abort must land before any new write
    task automatic t_rerun;
        issue(2'h0, 18'h0, 8'h40);
        repeat (6) @(posedge clk);
        #1 reset = 1'b1;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        t_powerup();
        issue(2'h0, 18'h9, 8'h66);
        rd(2'h1, 18'h9, 8'h5a ^ 8'h09);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        t_powerup();
        t_ident();
        t_abort();
        t_lowvpp();
        t_supply();
        t_idpin();
        t_rerun();
        end_sim();
    end
    // Run needs well under a thousand cycles; this limit leaves wide margin
    initial begin
        #100000;
        errors++;
        end_sim();
    end
endmodule
